// ---- rtl/efmc_top.sv ----
// Modulator control registers: integer, fractional, exact step, seed reload, resets.
// Assumes sck, sen, sdi arrive asynchronously.
// Operation
// - channel change rewrites only fractional register
// - four selectable seeds, config bits 1:0
// - seed reloads on new fractional frequency
// - power-on reset after 250 us
// - write to address zero soft resets
// - soft reset keeps serial mode
// - soft reset spares oscillator registers
module efmc_top
    import efmc_pkg::*;
#(
    parameter int POR_CNT = POR_CYCLES      // Power-on hold, in ref_clk cycles
) (
    input  wire logic              ref_clk,    // Phase detector clock, 100 MHz
    input  wire logic              rst_n,      // Synchronous reset, active low
    input  wire logic              sck,        // Serial clock pin
    input  wire logic              sen,        // Serial enable pin
    input  wire logic              sdi,        // Serial data pin
    output logic                   sdo,        // Serial data out
    output logic                   sdo_oe,     // Serial data out enable
    output logic [DATA_W-1:0]      int_div,    // Integer divider value
    output logic [DATA_W-1:0]      exact_step, // Exact frequency step count
    output logic [DATA_W-1:0]      frac_value, // Fractional value in use
    output logic                   frac_en,    // Fractional modulator enabled
    output logic                   mod_bypass, // Modulator bypassed
    output logic [DATA_W-1:0]      phase_acc,  // Fraction phase accumulator
    output logic                   por_busy    // Power-on reset in progress
);
    import efmc_pkg::*;
    typedef struct packed {
        logic [2:0]         sck_m;
        logic [2:0]         sen_m;
        logic [2:0]         sdi_m;
        logic [15:0]        por_cnt;
        logic               por_done;
        logic               spi_mode;
        logic [DATA_W-1:0]  int_div;
        logic [DATA_W-1:0]  frac;
        logic [DATA_W-1:0]  cfg;
        logic [DATA_W-1:0]  exact;
        logic [DATA_W-1:0]  vco;
        logic [DATA_W-1:0]  acc;
        logic               reload;
        logic [DATA_W-1:0]  rd;
    } efmc_st_s;
    efmc_st_s st_reg, st_next;
    efmc_wr_if wr ();

    // Start phase per select code; non-binary patterns decorrelate spurs
    function automatic logic [DATA_W-1:0] seed_of(input logic [1:0] sel);
        case (sel)
            2'h0:    seed_of = SEED_ZERO;
            2'h1:    seed_of = SEED_BINARY;
            2'h2:    seed_of = SEED_RANDOM;
            default: seed_of = SEED_ALT;
        endcase
    endfunction

    // Serial port held idle until the power-on hold ends
    efmc_serial u_ser (
        .ref_clk (ref_clk),
        .rst_n   (rst_n & st_reg.por_done),
        .sck_s   (st_reg.sck_m[1]),
        .sen_s   (st_reg.sen_m[1]),
        .sdi_s   (st_reg.sdi_m[1]),
        .sdo     (sdo),
        .sdo_oe  (sdo_oe),
        .bus     (wr.port)
    );

    // Any accepted write to address zero is a soft reset
    logic soft_rst;
    assign soft_rst = wr.wr_valid && wr.wr_addr == ADDR_RESET_ID;

    always_comb begin
        st_next       = st_reg;
        // Two-flop synchronisers; only the second stage feeds the port
        st_next.sck_m = {st_reg.sck_m[1:0], sck};
        st_next.sen_m = {st_reg.sen_m[1:0], sen};
        st_next.sdi_m = {st_reg.sdi_m[1:0], sdi};
        st_next.reload = 1'b0;
        // Power-on hold first, then soft reset, then ordinary writes
        if (!st_reg.por_done) begin
            st_next.por_cnt = st_reg.por_cnt + 16'h0001;
            if (st_reg.por_cnt == 16'(POR_CNT - 1)) begin
                st_next.por_done = 1'b1;
            end
        end else if (soft_rst) begin
            st_next.int_div = INT_DIV_RST;
            st_next.frac    = FRAC_RST;
            st_next.cfg     = MOD_CFG_RST;
            st_next.exact   = EXACT_RST;
            st_next.reload  = 1'b1;
            // Serial mode and oscillator registers kept
        end else if (wr.wr_valid) begin
            st_next.spi_mode = 1'b1;
            case (wr.wr_addr)
                ADDR_INT_DIV: st_next.int_div = wr.wr_data;
                ADDR_FRAC: begin
                    st_next.frac   = wr.wr_data;
                    st_next.reload = 1'b1;
                end
                ADDR_VSPI:    st_next.vco   = wr.wr_data;
                ADDR_MOD_CFG: st_next.cfg   = wr.wr_data;
                ADDR_EXACT:   st_next.exact = wr.wr_data;
                default: ;
            endcase
        end
        // Seed on reload, else step by the fractional word when enabled
        if (st_reg.reload) begin
            st_next.acc = seed_of(st_reg.cfg[SEED_LSB+:2]);
        end else if (st_reg.cfg[FRAC_EN_BIT]) begin
            st_next.acc = st_reg.acc + st_reg.frac;
        end
        // Read word registered for the port's shift register
        case (wr.rd_addr)
            ADDR_RESET_ID: st_next.rd = CHIP_ID;
            ADDR_INT_DIV:  st_next.rd = st_reg.int_div;
            ADDR_FRAC:     st_next.rd = st_reg.frac;
            ADDR_VSPI:     st_next.rd = st_reg.vco;
            ADDR_MOD_CFG:  st_next.rd = st_reg.cfg;
            ADDR_EXACT:    st_next.rd = st_reg.exact;
            default:       st_next.rd = '0;
        endcase
        if (!rst_n) begin
            st_next          = '0;
            st_next.int_div  = INT_DIV_RST;
            st_next.frac     = FRAC_RST;
            st_next.cfg      = MOD_CFG_RST;
            st_next.exact    = EXACT_RST;
            st_next.vco      = VCO_RST;
        end
    end

    always_ff @(posedge ref_clk) begin
        st_reg <= st_next;
    end

    assign wr.rd_data = st_reg.rd;
    assign int_div    = st_reg.int_div;
    assign exact_step = st_reg.exact;
    assign frac_value = st_reg.frac;
    assign frac_en    = st_reg.cfg[FRAC_EN_BIT];
    assign mod_bypass = st_reg.cfg[BYPASS_BIT];
    assign phase_acc  = st_reg.acc;
    assign por_busy   = ~st_reg.por_done;

    // A fractional write taken by the core once the power-on hold is over
    sequence s_frac_write;
        st_reg.por_done && wr.wr_valid && wr.wr_addr == ADDR_FRAC;
    endsequence

    // Reload strobe, then the selected seed standing in the accumulator
    sequence s_seed_loaded;
        st_reg.reload ##1 phase_acc == seed_of($past(st_reg.cfg[SEED_LSB+:2]));
    endsequence

    property p_reload;
        @(posedge ref_clk) disable iff (!rst_n)
        s_frac_write |-> ##2 phase_acc == seed_of($past(st_reg.cfg[1:0], 1));
    endproperty
    chk_seed_reload: assert property (p_reload) else $error("seed not reloaded");
    chk_soft_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.por_done && soft_rst) |=> int_div == INT_DIV_RST && exact_step == EXACT_RST)
        else $error("soft reset missed");
    chk_vco_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
        soft_rst |=> $stable(st_reg.vco)) else $error("oscillator register cleared");
    chk_frac_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr.wr_valid && wr.wr_addr == ADDR_FRAC) |=> $stable(int_div) && $stable(exact_step))
        else $error("channel write disturbed steps");
    chk_por_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.por_cnt == 16'h0000 && !st_reg.por_done) |=> por_busy)
        else $error("power-on hold ended early");
    chk_seed_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_reg.reload |=> phase_acc == seed_of($past(st_reg.cfg[1:0])))
        else $error("wrong seed");
    chk_frac_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_frac_write |=> st_reg.reload)
        else $error("no reload after fractional write");
    chk_mode_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
        soft_rst |=> $stable(st_reg.spi_mode)) else $error("serial mode cleared");

    // Register core guards: reset values, hold, soft reset, writes, accumulator
    chk_reset_defaults: assert property (@(posedge ref_clk)
        !rst_n |=> int_div == INT_DIV_RST && frac_value == FRAC_RST
            && exact_step == EXACT_RST && por_busy)
        else $error("reset defaults missing");
    chk_por_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !st_reg.por_done |-> !wr.wr_valid)
        else $error("write accepted during power-on hold");
    chk_soft_cfg: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.por_done && soft_rst) |=> frac_value == FRAC_RST
            && frac_en == MOD_CFG_RST[FRAC_EN_BIT] && mod_bypass == MOD_CFG_RST[BYPASS_BIT])
        else $error("soft reset left configuration");
    chk_int_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.por_done && wr.wr_valid && wr.wr_addr == ADDR_INT_DIV)
            |=> int_div == $past(wr.wr_data))
        else $error("integer write lost");
    chk_step_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.por_done && wr.wr_valid && wr.wr_addr == ADDR_EXACT)
            |=> exact_step == $past(wr.wr_data))
        else $error("exact step write lost");
    chk_acc_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!st_reg.reload && !frac_en) |=> $stable(phase_acc))
        else $error("accumulator moved while disabled");
    chk_write_seed: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_frac_write |=> s_seed_loaded)
        else $error("fractional write did not reach the accumulator");
endmodule

// ---- rtl/efmc_pkg.sv ----
// Constants shared by the modulator control block and its serial port.
// Assumes a 24-bit register word and 5-bit register address on the serial link.
package efmc_pkg;
    localparam int          DATA_W         = 24;
    localparam int          ADDR_W         = 5;
    localparam int          FRAME_W        = 32;
    localparam logic [4:0]  ADDR_RESET_ID  = 5'h00;
    localparam logic [4:0]  ADDR_INT_DIV   = 5'h03;
    localparam logic [4:0]  ADDR_FRAC      = 5'h04;
    localparam logic [4:0]  ADDR_VSPI      = 5'h05;
    localparam logic [4:0]  ADDR_MOD_CFG   = 5'h06;
    localparam logic [4:0]  ADDR_EXACT     = 5'h0C;
    localparam int          SEED_LSB       = 0;
    localparam int          BYPASS_BIT     = 7;
    localparam int          FRAC_EN_BIT    = 11;
    localparam int          SOFT_RESET_BIT = 5;
    localparam logic [23:0] INT_DIV_RST    = 24'h000014;
    localparam logic [23:0] FRAC_RST       = 24'h000000;
    localparam logic [23:0] MOD_CFG_RST    = 24'h000082;
    localparam logic [23:0] EXACT_RST      = 24'h000000;
    localparam logic [23:0] VCO_RST        = 24'h000000;
    localparam logic [23:0] SEED_ZERO      = 24'h000000;
    localparam logic [23:0] SEED_BINARY    = 24'h800000;
    localparam logic [23:0] SEED_RANDOM    = 24'hB38FB9;
    localparam logic [23:0] SEED_ALT       = 24'h50F5A7;
    localparam int          POR_TIME_US    = 250;
    localparam int          CLK_MHZ        = 100;
    localparam int          POR_CYCLES     = POR_TIME_US * CLK_MHZ;
    // Arbitrary identification value
    localparam logic [23:0] CHIP_ID        = 24'h0A5A01;
endpackage

// ---- rtl/efmc_wr_if.sv ----
// Write strobe carrier between the serial port and the register core.
// Assumes both ends run on ref_clk.
interface efmc_wr_if;
    import efmc_pkg::*;
    logic              wr_valid;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic              rd_start;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    modport port (output wr_valid, wr_addr, wr_data, rd_start, rd_addr, input rd_data);
    modport core (input wr_valid, wr_addr, wr_data, rd_start, rd_addr, output rd_data);
endinterface

// ---- rtl/efmc_serial.sv ----
// Three-wire serial slave: 33-bit frames, R/W bit, 5-bit address, 24 data, 3-bit chip id.
// Assumes sck, sen, sdi synchronised by the caller; sen high frames a transfer.
module efmc_serial
    import efmc_pkg::*;
(
    input  wire logic   ref_clk,   // System clock
    input  wire logic   rst_n,     // Synchronous reset
    input  wire logic   sck_s,     // Synchronised serial clock
    input  wire logic   sen_s,     // Synchronised enable
    input  wire logic   sdi_s,     // Synchronised data in
    output logic        sdo,       // Serial data out
    output logic        sdo_oe,    // Data out drive enable
    efmc_wr_if.port     bus        // Write and read strobes
);
    import efmc_pkg::*;
    typedef struct packed {
        logic               sck_d;
        logic               sen_d;
        logic [5:0]         cnt;
        logic [FRAME_W-1:0] sh;
        logic               rd;
        logic [DATA_W-1:0]  out;
        logic               wr_v;
        logic [ADDR_W-1:0]  wa;
        logic [DATA_W-1:0]  wd;
        logic               rs;
        logic               rs_d;
    } efmc_ser_s;
    efmc_ser_s st_reg, st_next;
    always_comb begin
        st_next      = st_reg;
        st_next.sck_d = sck_s;
        st_next.sen_d = sen_s;
        st_next.wr_v = 1'b0;
        st_next.rs   = 1'b0;
        // Read word settles in the core one cycle after the address
        st_next.rs_d = st_reg.rs;
        if (!sen_s) begin
            st_next.cnt = 6'h00;
            st_next.rd  = 1'b0;
        end else if (sck_s && !st_reg.sck_d) begin
            st_next.sh  = {st_reg.sh[FRAME_W-2:0], sdi_s};
            st_next.cnt = st_reg.cnt + 6'h01;
            if (st_reg.cnt == 6'h05) begin
                st_next.rd = st_reg.sh[4];
                st_next.rs = st_reg.sh[4];
            end
        end else if (!sck_s && st_reg.sck_d && st_reg.rd && st_reg.cnt >= 6'h06) begin
            st_next.out = {st_reg.out[DATA_W-2:0], 1'b0};
        end
        if (st_reg.rs_d) begin
            st_next.out = bus.rd_data;
        end
        // Frame completes on sen falling after a full 33 bits with chip id 000;
        // the R/W bit has already left the 32-bit shift register
        if (!sen_s && st_reg.sen_d && st_reg.cnt == 6'h21 && !st_reg.rd
            && st_reg.sh[2:0] == 3'h0) begin
            st_next.wr_v = 1'b1;
            st_next.wa   = st_reg.sh[FRAME_W-1 -: ADDR_W];
            st_next.wd   = st_reg.sh[26:3];
        end
        if (!rst_n) begin
            st_next = '0;
        end
    end
    always_ff @(posedge ref_clk) begin
        st_reg <= st_next;
    end
    assign bus.wr_valid = st_reg.wr_v;
    assign bus.wr_addr  = st_reg.wa;
    assign bus.wr_data  = st_reg.wd;
    assign bus.rd_start = st_reg.rs;
    assign bus.rd_addr  = st_reg.sh[ADDR_W-1:0];
    assign sdo          = st_reg.out[DATA_W-1];
    assign sdo_oe       = st_reg.rd & sen_s;
endmodule

// ---- verif/efmc_host.sv ----
// Host controller model: sends 33-bit frames over the three-wire serial port.
// Assumes the device samples sdi on sck rise and shifts read data out on sck fall.
module efmc_host (
    output logic      sck, // Serial clock, still between frames
    output logic      sen, // Frame enable
    output logic      sdi, // Serial data to the device
    input  wire logic sdo  // Read data from the device
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sck = 1'b0;
        sen = 1'b0;
        sdi = 1'b0;
    end

    // One 33-bit frame: R/W, address, data, chip id, MSB first; read bits are
    // taken just before each sck fall, while the device holds them
    task automatic xfer(input logic rd, input logic [4:0] addr, input logic [23:0] data,
                        input logic [2:0] id, output logic [23:0] rdata);
        logic [32:0] frame;
        frame = {rd, addr, data, id};
        rdata = '0;
        #200;
        sen = 1'b1;
        for (int i = 32; i >= 0; i--) begin
            sdi = frame[i];
            #80;
            sck = 1'b1;
            #80;
            if (i <= 27 && i >= 4) rdata = {rdata[22:0], sdo};
            sck = 1'b0;
        end
        #80;
        sen = 1'b0;
        // Released line must not keep its last level
        sdi = ~sdi;
    endtask
endmodule

// ---- verif/efmc_top_tb_top.sv ----
// Testbench for the modulator control block: registers, seed reload, resets.
// Assumes the host model in efmc_host.sv and a shortened power-on count.
module efmc_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import efmc_pkg::*;

    localparam int     POR = 20;
    logic              ref_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              sck, sen, sdi, sdo, sdo_oe, frac_en, mod_bypass, por_busy;
    logic [DATA_W-1:0] int_div, exact_step, frac_value, phase_acc, q;
    logic [23:0]       seeds [4] = '{SEED_ZERO, SEED_BINARY, SEED_RANDOM, SEED_ALT};
    int                n_checks = 0;
    int                num_errors = 0;

    always #5 ref_clk = ~ref_clk;

    efmc_host efmc_host_i (.sck(sck), .sen(sen), .sdi(sdi), .sdo(sdo));

    efmc_top #(.POR_CNT(POR)) efmc_top_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .sen(sen), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe), .int_div(int_div), .exact_step(exact_step),
        .frac_value(frac_value), .frac_en(frac_en), .mod_bypass(mod_bypass),
        .phase_acc(phase_acc), .por_busy(por_busy));

    task automatic check(input string name, input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        efmc_host_i.xfer(1'b0, a, d, 3'b000, q);
        repeat (10) @(negedge ref_clk);
    endtask

    task automatic rd(input logic [4:0] a, input logic [23:0] exp, input string name);
        efmc_host_i.xfer(1'b1, a, 24'h000000, 3'b000, q);
        check(name, q, exp);
        repeat (4) @(negedge ref_clk);
        check("sdo_released", {23'h0, sdo_oe}, 24'h000000);
    endtask

    task automatic check_defaults;
        check("int_div", int_div, INT_DIV_RST);
        check("frac", frac_value, FRAC_RST);
        check("exact", exact_step, EXACT_RST);
        check("frac_en", {23'h0, frac_en}, {23'h0, MOD_CFG_RST[FRAC_EN_BIT]});
        check("bypass", {23'h0, mod_bypass}, {23'h0, MOD_CFG_RST[BYPASS_BIT]});
    endtask

    // Power-on hold after every reset release, then defaults
    task automatic do_reset;
        int cnt;
        @(posedge ref_clk);
        #1 rst_n = 1'b0;
        repeat (16) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        @(posedge ref_clk);
        #1 check("por_busy", {23'h0, por_busy}, 24'h000001);
        cnt = 0;
        while (por_busy !== 1'b0 && cnt < POR + 10) begin
            @(posedge ref_clk);
            #1 cnt++;
        end
        check("por_len", {23'h0, (cnt >= POR - 2 && cnt < POR + 10)}, 24'h000001);
        if (por_busy !== 1'b0) complete_run();
        check_defaults();
    endtask

    // Fractional write, then the selected seed must appear and accumulate
    task automatic seed_watch(input int sel, input logic [23:0] frac);
        int k;
        efmc_host_i.xfer(1'b0, ADDR_FRAC, frac, 3'b000, q);
        for (k = 0; k < 60 && frac_value !== frac; k++) @(negedge ref_clk);
        check("frac_val", frac_value, frac);
        if (k == 60) complete_run();
        @(negedge ref_clk);
        check("seed_load", phase_acc, seeds[sel]);
        @(negedge ref_clk);
        check("acc_step", phase_acc, seeds[sel] + frac);
    endtask

    task automatic t_exact;
        wr(ADDR_INT_DIV, 24'h00002D);
        wr(ADDR_EXACT, 24'h000C00);
        wr(ADDR_MOD_CFG, 24'h000802);
        check("frac_on", {22'h0, frac_en, mod_bypass}, 24'h000002);
        seed_watch(2, 24'h938000);
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_MOD_CFG, 24'h000800 | 24'(s));
            seed_watch(s, 24'h938001 + 24'(s));
        end
        seed_watch(3, 24'h93EAAB);
        check("int_kept", int_div, 24'h00002D);
        check("exact_kept", exact_step, 24'h000C00);
        rd(ADDR_FRAC, 24'h93EAAB, "frac_rb");
        efmc_host_i.xfer(1'b0, ADDR_INT_DIV, 24'h000055, 3'b101, q);
        repeat (10) @(negedge ref_clk);
        check("bad_id", int_div, 24'h00002D);
    endtask

    task automatic t_soft;
        wr(ADDR_VSPI, 24'h00ABCD);
        wr(ADDR_RESET_ID, 24'h000020);
        check_defaults();
        rd(ADDR_VSPI, 24'h00ABCD, "osc_kept");
        wr(ADDR_INT_DIV, 24'h000030);
        rd(ADDR_INT_DIV, 24'h000030, "port_alive");
    endtask

    initial begin
        do_reset();
        wr(ADDR_RESET_ID, 24'h000020);
        rd(ADDR_RESET_ID, CHIP_ID, "chip_id");
        rd(ADDR_INT_DIV, INT_DIV_RST, "int_rb");
        t_exact();
        t_soft();
        t_exact();
        do_reset();
        complete_run();
    end
endmodule
